// *** sfa_regs.vh ***
/*
 Constants of the subtract-family arithmetic unit: opcodes, field positions,
 reset values and cycle counts.
 Assumes the decoder presents one instruction word and both operands at a time.
*/
`ifndef SFA_REGS_VH
`define SFA_REGS_VH
`define SFA_OP_UNSIGNED 6'h21
`define SFA_OP_MAGNITUDE 6'h23
`define SFA_OP_SIGNED 6'h35
`define SFA_OP_SIGNED_EXT 6'h37
`define SFA_INSTR_HI 31
`define SFA_INSTR_LO 26
`define SFA_WZ_BIT 25
`define SFA_WC_BIT 24
`define SFA_WR_BIT 23
`define SFA_IMM_BIT 22
`define SFA_DEST_HI 17
`define SFA_DEST_LO 9
`define SFA_SRC_HI 8
`define SFA_SRC_LO 0
`define SFA_CLOCKS 3'h4
`define SFA_FLAG_RESET 1'h0
`define SFA_COUNT_RESET 3'h0
`define SFA_COUNT_FIRST 3'h1
`define SFA_WORD_RESET 32'h00000000
`define SFA_ADDR_RESET 9'h000
`endif

// *** sfa_subtract_unit.v ***
/*
 Subtract-family arithmetic unit: unsigned, magnitude, signed and signed
 extended subtraction with zero and carry flags and optional write-back.
 Assumes the decoder holds instr, dest_value and src_reg_value stable from
 the start pulse until done, and that the register file writes wb_data to
 wb_addr on a wb_en pulse.
*/
`timescale 1ns/1ps
`include "sfa_regs.vh"
////////////////////////////////////////////////////////////////////////
// Borrow-producing subtractor, one per operand path
module sfa_sub_stage #(
    parameter WIDTH = 32
) (
    input wire [WIDTH-1:0] minuend,
    input wire [WIDTH-1:0] subtrahend,
    input wire borrow_in,
    output wire [WIDTH-1:0] difference,
    output wire borrow_out
);
    wire [WIDTH:0] wide_diff;
    // Extra top bit catches the unsigned borrow
    assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrow_in};
    assign difference = wide_diff[WIDTH-1:0];
    assign borrow_out = wide_diff[WIDTH];
endmodule
////////////////////////////////////////////////////////////////////////
// Wide zero test, instanced once per subtractor for the zero flag
module sfa_zero_detect #(
    parameter WIDTH = 32
) (
    input wire [WIDTH-1:0] value,
    output wire is_zero
);
    assign is_zero = (value == {WIDTH{1'b0}});
endmodule
////////////////////////////////////////////////////////////////////////
// Sequenced subtract unit
module sfa_subtract_unit (
    input wire clk,
    input wire srst,
    input wire start,
    input wire [31:0] instr,
    input wire [31:0] dest_value,
    input wire [31:0] src_reg_value,
    output reg busy_q,
    output reg done_q,
    output reg illegal_q,
    output reg wb_en_q,
    output reg [8:0] wb_addr_q,
    output reg [31:0] wb_data_q,
    output reg null_flag_q,
    output reg borrow_flag_q
);
    ////////////////////////////////////////////////////////////////////
    // Sequencer states
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;
    ////////////////////////////////////////////////////////////////////
    // Registers and their next values
    reg state_q;
    reg state_d;
    reg [2:0] count_q;
    reg [2:0] count_d;
    reg [31:0] instr_q;
    reg [31:0] instr_d;
    reg busy_d;
    reg done_d;
    reg illegal_d;
    reg wb_en_d;
    reg [8:0] wb_addr_d;
    reg [31:0] wb_data_d;
    reg null_flag_d;
    reg borrow_flag_d;
    ////////////////////////////////////////////////////////////////////
    // Decoded fields of the held instruction
    reg [5:0] op;
    reg write_null_flag_effect;
    reg write_borrow_flag_effect;
    reg no_writeback_effect;
    reg literal_sel;
    reg [8:0] dest_field;
    reg [31:0] src;
    reg [31:0] mag;
    reg legal;
    reg last_clock;
    ////////////////////////////////////////////////////////////////////
    // Datapath nets
    wire [31:0] plain_diff;
    wire plain_borrow;
    wire [31:0] mag_diff;
    wire mag_borrow;
    wire [31:0] chain_diff;
    wire plain_is_zero;
    wire mag_is_zero;
    wire chain_is_zero;
    wire [32:0] sum;
    wire plain_ovf;
    wire chain_ovf;
    reg [31:0] result;
    reg z_new;
    reg c_new;
    ////////////////////////////////////////////////////////////////////
    // Field decode
    always @* begin
        op = instr_q[`SFA_INSTR_HI:`SFA_INSTR_LO];
        write_null_flag_effect = instr_q[`SFA_WZ_BIT];
        write_borrow_flag_effect = instr_q[`SFA_WC_BIT];
        // R bit set means written; clear means no write-back
        no_writeback_effect = ~instr_q[`SFA_WR_BIT];
        literal_sel = instr_q[`SFA_IMM_BIT];
        dest_field = instr_q[`SFA_DEST_HI:`SFA_DEST_LO];
        // Literal is zero-extended, never sign-extended
        if (literal_sel) begin
            src = {23'h000000, instr_q[`SFA_SRC_HI:`SFA_SRC_LO]};
        end else begin
            src = src_reg_value;
        end
        // Most negative source maps to itself; its magnitude is still right unsigned
        if (src[31]) begin
            mag = ~src + 32'h00000001;
        end else begin
            mag = src;
        end
        case (op)
            `SFA_OP_UNSIGNED: legal = 1'b1;
            `SFA_OP_MAGNITUDE: legal = 1'b1;
            `SFA_OP_SIGNED: legal = 1'b1;
            `SFA_OP_SIGNED_EXT: legal = 1'b1;
            default: legal = 1'b0;
        endcase
        last_clock = (count_q == `SFA_CLOCKS - 3'h1);
    end
    ////////////////////////////////////////////////////////////////////
    // Three subtractors: plain, magnitude and carry-chained
    sfa_sub_stage #(
        .WIDTH(32)
    ) plain_stage (
        .minuend(dest_value),
        .subtrahend(src),
        .borrow_in(1'b0),
        .difference(plain_diff),
        .borrow_out(plain_borrow)
    );
    sfa_sub_stage #(
        .WIDTH(32)
    ) mag_stage (
        .minuend(dest_value),
        .subtrahend(mag),
        .borrow_in(1'b0),
        .difference(mag_diff),
        .borrow_out(mag_borrow)
    );
    sfa_sub_stage #(
        .WIDTH(32)
    ) chain_stage (
        .minuend(dest_value),
        .subtrahend(src),
        .borrow_in(borrow_flag_q),
        .difference(chain_diff),
        .borrow_out()
    );
    // One zero test per subtractor
    sfa_zero_detect #(
        .WIDTH(32)
    ) plain_zero (
        .value(plain_diff),
        .is_zero(plain_is_zero)
    );
    sfa_zero_detect #(
        .WIDTH(32)
    ) mag_zero (
        .value(mag_diff),
        .is_zero(mag_is_zero)
    );
    sfa_zero_detect #(
        .WIDTH(32)
    ) chain_zero (
        .value(chain_diff),
        .is_zero(chain_is_zero)
    );
    // Carry of dest plus raw source, used for a negative magnitude operand
    assign sum = {1'b0, dest_value} + {1'b0, src};
    // Overflow when signs differ and the result sign leaves the minuend's
    assign plain_ovf = (dest_value[31] != src[31]) && (plain_diff[31] != dest_value[31]);
    // Carry is folded into the result, so the same sign test covers it
    assign chain_ovf = (dest_value[31] != src[31]) && (chain_diff[31] != dest_value[31]);
    ////////////////////////////////////////////////////////////////////
    // Result and flag candidates per operation
    always @* begin
        result = 32'h00000000;
        z_new = null_flag_q;
        c_new = borrow_flag_q;
        case (op)
            `SFA_OP_UNSIGNED: begin
                result = plain_diff;
                z_new = plain_is_zero;
                c_new = plain_borrow;
            end
            `SFA_OP_MAGNITUDE: begin
                result = mag_diff;
                z_new = mag_is_zero;
                if (src[31]) begin
                    c_new = ~sum[32];
                end else begin
                    c_new = mag_borrow;
                end
            end
            `SFA_OP_SIGNED: begin
                result = plain_diff;
                z_new = plain_is_zero;
                c_new = plain_ovf;
            end
            `SFA_OP_SIGNED_EXT: begin
                result = chain_diff;
                // Zero only survives a chain whose every word was zero
                z_new = null_flag_q && chain_is_zero;
                c_new = chain_ovf;
            end
            default: begin
                result = 32'h00000000;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    // Next-state logic: four clocks from start to done
    always @* begin
        state_d = state_q;
        count_d = count_q;
        instr_d = instr_q;
        busy_d = busy_q;
        done_d = 1'b0;
        illegal_d = illegal_q;
        wb_en_d = 1'b0;
        wb_addr_d = wb_addr_q;
        wb_data_d = wb_data_q;
        null_flag_d = null_flag_q;
        borrow_flag_d = borrow_flag_q;
        case (state_q)
            ST_IDLE: begin
                // A start seen while busy never reaches this branch
                if (start) begin
                    instr_d = instr;
                    busy_d = 1'b1;
                    illegal_d = 1'b0;
                    count_d = `SFA_COUNT_FIRST;
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                count_d = count_q + 3'h1;
                if (last_clock) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                    illegal_d = ~legal;
                    // Unknown codes leave registers and flags alone
                    if (legal) begin
                        wb_en_d = ~no_writeback_effect;
                        wb_addr_d = dest_field;
                        wb_data_d = result;
                        if (write_null_flag_effect) begin
                            null_flag_d = z_new;
                        end
                        if (write_borrow_flag_effect) begin
                            borrow_flag_d = c_new;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    // Control registers
    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            count_q <= `SFA_COUNT_RESET;
            instr_q <= `SFA_WORD_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            wb_en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            instr_q <= instr_d;
            busy_q <= busy_d;
            done_q <= done_d;
            illegal_q <= illegal_d;
            wb_en_q <= wb_en_d;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Result and flag registers
    always @(posedge clk) begin
        if (srst) begin
            wb_addr_q <= `SFA_ADDR_RESET;
            wb_data_q <= `SFA_WORD_RESET;
            null_flag_q <= `SFA_FLAG_RESET;
            borrow_flag_q <= `SFA_FLAG_RESET;
        end else begin
            wb_addr_q <= wb_addr_d;
            wb_data_q <= wb_data_d;
            null_flag_q <= null_flag_d;
            borrow_flag_q <= borrow_flag_d;
        end
    end
endmodule

// *** sfa_asserts.sv ***
/* Checker on sfa_subtract_unit ports, bound after the module.
 Assumes one clock and srst synchronous, active high. */
`timescale 1ns/1ps
`include "sfa_regs.vh"
module sfa_asserts(input clk, srst, start, busy_q, done_q, illegal_q, wb_en_q, null_flag_q,
    borrow_flag_q, input [31:0] instr, wb_data_q, input [8:0] wb_addr_q);
reg [31:0] ins_q;
// Keeps the taken word, since instr may move after done
always @(posedge clk) if (start && !busy_q) ins_q <= instr;
wire ext = ins_q[31:26] == `SFA_OP_SIGNED_EXT;
default clocking @(posedge clk); endclocking
default disable iff (srst);
sequence go_s; start && !busy_q; endsequence
sequence fin_s; busy_q[*3] ##1 (done_q && !busy_q); endsequence
done_time_a: assert property (go_s |=> fin_s) else $error("late done");
done_once_a: assert property (done_q |=> !done_q) else $error("long done");
write_gate_a: assert property (done_q |-> wb_en_q == (ins_q[23] && !illegal_q)) else $error("bad write");
write_addr_a: assert property (wb_en_q |-> wb_addr_q == ins_q[17:9]) else $error("bad addr");
zero_hold_a: assert property (done_q && !ins_q[25] |-> $stable(null_flag_q)) else $error("zero moved");
carry_hold_a: assert property (!done_q && !$past(srst) |-> $stable(borrow_flag_q)) else $error("carry");
zero_set_a: assert property (done_q && ins_q[25] && !illegal_q && !ext |->
    null_flag_q == (wb_data_q == 32'h0)) else $error("bad zero");
ext_zero_a: assert property (done_q && ins_q[25] && ext |-> !null_flag_q || $past(null_flag_q))
    else $error("zero rose");
endmodule
bind sfa_subtract_unit sfa_asserts sfa_asserts_i(.clk(clk), .srst(srst), .start(start), .busy_q(busy_q),
    .done_q(done_q), .illegal_q(illegal_q), .wb_en_q(wb_en_q), .null_flag_q(null_flag_q),
    .borrow_flag_q(borrow_flag_q), .instr(instr), .wb_data_q(wb_data_q), .wb_addr_q(wb_addr_q));

// *** sfa_regfile.sv ***
/* Register file and decoder model facing sfa_subtract_unit.
 Assumes the bench loads mem and holds instr until done. */
`timescale 1ns/1ps
module sfa_regfile(input clk, input [31:0] instr, input wb_en_q, input [8:0] wb_addr_q,
    input [31:0] wb_data_q, output [31:0] dest_value, output [31:0] src_reg_value);
reg [31:0] mem [0:511];
assign dest_value = mem[instr[17:9]];
assign src_reg_value = mem[instr[8:0]];
always @(posedge clk) if (wb_en_q) mem[wb_addr_q] <= wb_data_q;
endmodule

// *** sfa_subtract_unit_bench.sv ***
/* Bench for sfa_subtract_unit: corner and random subtracts.
 Assumes sfa_regfile and sfa_asserts compiled first. */
`timescale 1ns/1ps
module sfa_subtract_unit_bench;
reg clk = 0, srst = 1, start = 0, mz = 0, mc = 0;
reg [31:0] instr = 32'h0, rv;
wire [31:0] dest_value, src_reg_value, wb_data_q;
wire [8:0] wb_addr_q;
wire busy_q, done_q, illegal_q, wb_en_q, null_flag_q, borrow_flag_q;
integer n_fail = 0, n_compared = 0, seed = 29, cyc = 0, k;
sfa_subtract_unit sfa_subtract_unit_i(.*);
sfa_regfile sfa_regfile_i(.*);
initial forever #5 clk = ~clk;
task end_sim; begin
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
end endtask
// Far above 50 runs of 5 cycles
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin n_fail = n_fail + 1; end_sim; end
end
task chk(input [31:0] g, x); begin
    n_compared = n_compared + 1;
    if (g !== x) begin n_fail = n_fail + 1; $display("CHECK FAILED %0t got %h", $time, g); end
end endtask
function [33:0] model(input [5:0] op, input [31:0] d, s);
    reg [32:0] t; reg [31:0] m, r; reg n, c;
    begin
        n = op == 6'h23 && s[31];
        m = n ? -s : s;
        r = d - m - (op == 6'h37 ? mc : 1'b0);
        t = {1'b0, d} + s;
        c = op[4] ? d[31] != s[31] && r[31] != d[31] : n ? ~t[32] : m > d;
        model = {r == 32'h0 && (op != 6'h37 || mz), c, r};
    end
endfunction
task run(input [5:0] op, input [3:0] f, input [31:0] d, s);
    reg [8:0] a; reg [33:0] e; reg l;
    begin
        a = $random(seed);
        l = op == 6'h21 || op == 6'h23 || op == 6'h35 || op == 6'h37;
        sfa_regfile_i.mem[a] = d;
        sfa_regfile_i.mem[a ^ 9'h1] = s;
        e = model(op, d, f[0] ? {23'h0, s[8:0]} : s);
        instr = {op, f, 4'hF, a, f[0] ? s[8:0] : a ^ 9'h1};
        start = 1;
        // Second start cycle falls in busy and must be ignored
        repeat (2) @(posedge clk) #1;
        start = 0;
        k = 1;
        while (done_q !== 1'b1 && k < 9) begin @(posedge clk) #1; k = k + 1; end
        chk(k, 32'h3);
        chk(illegal_q, !l);
        chk({null_flag_q, borrow_flag_q}, {f[3] & l ? e[33] : mz, f[2] & l ? e[32] : mc});
        if (l) chk(wb_data_q, e[31:0]);
        mz = f[3] & l ? e[33] : mz;
        mc = f[2] & l ? e[32] : mc;
        @(posedge clk) #1;
        chk(sfa_regfile_i.mem[a], f[1] & l ? e[31:0] : d);
    end
endtask
initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    run(6'h21, 4'hE, 32'h2, 32'h3);
    run(6'h23, 4'hE, 32'h3, 32'hFFFFFFFD);
    run(6'h35, 4'hE, 32'h7FFFFFFE, 32'hFFFFFFFE);
    run(6'h35, 4'hF, 32'h0, 32'hFFFFF1FF);
    run(6'h21, 4'h0, 32'h5, 32'h9);
    run(6'h21, 4'hE, 32'h1, 32'h2);
    run(6'h37, 4'hE, 32'h0, 32'h0);
    run(6'h21, 4'hE, 32'h2, 32'h2);
    run(6'h37, 4'hE, 32'h1, 32'h1);
    run(6'h22, 4'hE, 32'h1, 32'h1);
    repeat (40) begin
        rv = $random(seed);
        run({1'b1, rv[1], 1'b0, rv[1], rv[0], 1'b1}, rv[5:2], $random(seed), $random(seed));
    end
    end_sim;
end
endmodule
